// ---- core/snsp_top.v ----
// Our own choices: the register addresses and register access over APB.
`include "snsp_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module snsp_top #(
	parameter [31:0] PACK_T0_CYC = `SNSP_T0_MS * 1000 * `SNSP_CLK_MHZ,
	parameter [31:0] PACK_T1_CYC = `SNSP_T1_MS * 1000 * `SNSP_CLK_MHZ,
	parameter [31:0] PACK_T2_CYC = `SNSP_T2_MS * 1000 * `SNSP_CLK_MHZ,
	parameter [31:0] PACK_T3_CYC = `SNSP_T3_SEC * 1000000 * `SNSP_CLK_MHZ,
	parameter [31:0] BLINK_CYC = `SNSP_BLINK_MS * 1000 * `SNSP_CLK_MHZ,
	parameter [15:0] LOCAL_PORT_BASE = 16'h2710
) (
	input wire clock,
	input wire nrst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire ser_valid,
	input wire [7:0] ser_data,
	input wire modem_ctrl_in,
	input wire sess_active,
	input wire sess_open_dev,
	input wire sess_open_net,
	input wire sess_closed,
	input wire status_seg_req,
	output reg seg_release,
	output reg seg_include_buffered,
	output reg sess_drop,
	output reg hard_close_en,
	output reg com_port_ctrl_en,
	output reg send_term_type,
	output reg password_req,
	output reg state_led,
	output reg s2n_flush,
	output reg n2s_flush,
	output reg escape_en,
	output reg ring_ip_en,
	output reg [31:0] remote_ip,
	output reg [15:0] remote_port,
	output reg [15:0] local_port
);

	// Trailer tracking states
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_TRAIL = 2'b10;

	reg [7:0] disc_ff;
	reg [7:0] flush_ff;
	reg [7:0] pack_ff;
	reg [15:0] trig_ff;
	reg [2:0] opt_ff;
	reg [31:0] rip_ff;
	reg [15:0] rport_ff;
	reg mctl_prev_ff;
	reg [7:0] prev_char_ff;
	reg [15:0] pend_ff;
	reg [31:0] timer_ff;
	reg [31:0] blink_cnt_ff;
	reg blink_ff;
	reg [1:0] state_ff;
	reg [1:0] trail_ff;
	reg [31:0] nxt_rdata;
	reg nxt_err;
	reg [31:0] wait_cyc;
	reg [1:0] nxt_state;
	reg [1:0] nxt_trail;
	reg nxt_release;
	wire apb_done;
	wire apb_wr;
	wire alt_en;
	wire [1:0] iv_sel;
	wire [1:0] trail_sel;
	wire seq_mode;
	wire imm_mode;
	wire [7:0] trig1;
	wire [7:0] trig2;
	wire trig_hit;
	wire timeout;
	wire mctl_fall;
	wire new_sess;

	// One wait state keeps read data and ready straight from flops
	assign apb_done = psel & penable & pready;
	assign apb_wr = apb_done & pwrite;

	// Alternate packing gates every packing field; standard scheme falls back to zeros
	assign alt_en = flush_ff[`SNSP_FL_ALT];
	assign iv_sel = alt_en ? pack_ff[`SNSP_PK_IV_HI:`SNSP_PK_IV_LO] : `SNSP_IV_12MS;
	assign trail_sel = alt_en ? pack_ff[`SNSP_PK_TR_HI:`SNSP_PK_TR_LO] : `SNSP_TR_NONE;
	assign seq_mode = alt_en & pack_ff[`SNSP_PK_SEQ];
	assign imm_mode = alt_en & pack_ff[`SNSP_PK_IMM];
	assign trig1 = trig_ff[7:0];
	assign trig2 = trig_ff[15:8];

	// A zero first trigger disables both; pair mode needs the first then the second
	assign trig_hit = ser_valid & (trig1 != `SNSP_NO_CHAR) &
		(seq_mode ? (prev_char_ff == trig1) & (ser_data == trig2) :
		((ser_data == trig1) | (ser_data == trig2)));

	assign timeout = (timer_ff == 32'h00000000) & (pend_ff != 16'h0000) & ~ser_valid;
	assign mctl_fall = mctl_prev_ff & ~modem_ctrl_in;
	assign new_sess = sess_open_dev | sess_open_net;

	// Wait time lookup; code 11 is the longest setting
	always @* begin
		case (iv_sel)
			`SNSP_IV_12MS: wait_cyc = PACK_T0_CYC;
			`SNSP_IV_52MS: wait_cyc = PACK_T1_CYC;
			`SNSP_IV_250MS: wait_cyc = PACK_T2_CYC;
			default: wait_cyc = PACK_T3_CYC;
		endcase
	end

	// Read mux; unmapped addresses answer zero with an error
	always @* begin
		nxt_rdata = `SNSP_RST_WORD;
		nxt_err = 1'b0;
		case (paddr)
			`SNSP_ADDR_DISC: nxt_rdata = {24'h000000, disc_ff};
			`SNSP_ADDR_FLUSH: nxt_rdata = {24'h000000, flush_ff};
			`SNSP_ADDR_PACK: nxt_rdata = {24'h000000, pack_ff};
			`SNSP_ADDR_TRIG: nxt_rdata = {16'h0000, trig_ff};
			`SNSP_ADDR_OPT: nxt_rdata = {29'h00000000, opt_ff};
			`SNSP_ADDR_RIP: nxt_rdata = rip_ff;
			`SNSP_ADDR_RPORT: nxt_rdata = {16'h0000, rport_ff};
			`SNSP_ADDR_STAT: nxt_rdata = {local_port, pend_ff[13:0], state_led, sess_active};
			default: nxt_err = 1'b1;
		endcase
	end

	// APB handshake: ready rises one cycle into the access phase
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pready <= 1'b0;
			prdata <= `SNSP_RST_WORD;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
			prdata <= (psel & penable & ~pready & ~pwrite) ? nxt_rdata : `SNSP_RST_WORD;
			pslverr <= psel & penable & ~pready & nxt_err;
		end
	end

	// Register file; stored bytes are kept whole except the option register, which keeps pwdata[2:0]; unassigned bits steer nothing
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			disc_ff <= `SNSP_RST_BYTE;
			flush_ff <= `SNSP_RST_BYTE;
			pack_ff <= `SNSP_RST_BYTE;
			trig_ff <= `SNSP_RST_PORT;
			opt_ff <= `SNSP_RST_OPT;
			rip_ff <= `SNSP_RST_WORD;
			rport_ff <= `SNSP_RST_PORT;
		end else if (apb_wr) begin
			case (paddr)
				`SNSP_ADDR_DISC: disc_ff <= pwdata[7:0];
				`SNSP_ADDR_FLUSH: flush_ff <= pwdata[7:0];
				`SNSP_ADDR_PACK: pack_ff <= pwdata[7:0];
				`SNSP_ADDR_TRIG: trig_ff <= pwdata[15:0];
				`SNSP_ADDR_OPT: opt_ff <= pwdata[2:0];
				`SNSP_ADDR_RIP: rip_ff <= pwdata;
				`SNSP_ADDR_RPORT: rport_ff <= pwdata[15:0];
				default: disc_ff <= disc_ff;
			endcase
		end
	end

	// Level outputs copy their policy bits; hard_close_en takes the inverse of its bit
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			hard_close_en <= 1'b0;
			com_port_ctrl_en <= 1'b0;
			password_req <= 1'b0;
			escape_en <= 1'b0;
			ring_ip_en <= 1'b0;
			remote_ip <= `SNSP_RST_WORD;
			remote_port <= `SNSP_RST_PORT;
		end else begin
			hard_close_en <= ~disc_ff[`SNSP_DISC_NOHARD];
			com_port_ctrl_en <= disc_ff[`SNSP_DISC_COMCTL];
			password_req <= disc_ff[`SNSP_DISC_PASSWD];
			escape_en <= opt_ff[`SNSP_OPT_ESC];
			ring_ip_en <= opt_ff[`SNSP_OPT_RING];
			remote_ip <= rip_ff;
			remote_port <= rport_ff;
		end
	end

	// Session events: drops, flushes, terminal type announcement
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			mctl_prev_ff <= 1'b0;
			sess_drop <= 1'b0;
			send_term_type <= 1'b0;
			s2n_flush <= 1'b0;
			n2s_flush <= 1'b0;
		end else begin
			mctl_prev_ff <= modem_ctrl_in;
			// Only a high-to-low edge counts, a low level alone never drops
			sess_drop <= sess_active & ((disc_ff[`SNSP_DISC_MCTL] & mctl_fall) |
				(disc_ff[`SNSP_DISC_EOT] & disc_ff[`SNSP_DISC_COMCTL] &
				ser_valid & (ser_data == `SNSP_EOT_CHAR)));
			send_term_type <= sess_open_dev & disc_ff[`SNSP_DISC_COMCTL];
			s2n_flush <= (sess_open_dev & flush_ff[`SNSP_FL_S2N_DEV]) |
				(sess_open_net & flush_ff[`SNSP_FL_S2N_NET]) |
				(sess_closed & flush_ff[`SNSP_FL_S2N_DISC]);
			n2s_flush <= (sess_open_dev & flush_ff[`SNSP_FL_N2S_DEV]) |
				(sess_open_net & flush_ff[`SNSP_FL_N2S_NET]) |
				(sess_closed & flush_ff[`SNSP_FL_N2S_DISC]);
		end
	end

	// Local port steps per new session when auto-increment is on
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			local_port <= `SNSP_RST_PORT;
		end else if (local_port == `SNSP_RST_PORT) begin
			local_port <= LOCAL_PORT_BASE;
		end else if (new_sess & opt_ff[`SNSP_OPT_AINC]) begin
			local_port <= local_port + 16'h0001;
		end
	end

	// Trailer state machine decides when a trigger releases the segment
	always @* begin
		nxt_state = state_ff;
		nxt_trail = trail_ff;
		nxt_release = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				if (trig_hit) begin
					if ((trail_sel == `SNSP_TR_ONE) | (trail_sel == `SNSP_TR_TWO)) begin
						nxt_state = ST_TRAIL;
						nxt_trail = trail_sel;
					end else begin
						nxt_release = 1'b1;
					end
				end else if (timeout | status_seg_req) begin
					nxt_release = 1'b1;
				end
			end
			ST_TRAIL: begin
				if (ser_valid) begin
					nxt_trail = trail_ff - 2'h1;
					if (trail_ff == `SNSP_TR_ONE) begin
						nxt_state = ST_IDLE;
						nxt_release = 1'b1;
					end
				end else if (timeout | status_seg_req) begin
					nxt_state = ST_IDLE;
					nxt_release = 1'b1;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	// Pending count, wait timer and release strobes
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_ff <= ST_IDLE;
			trail_ff <= `SNSP_TR_NONE;
			prev_char_ff <= `SNSP_NO_CHAR;
			pend_ff <= 16'h0000;
			timer_ff <= 32'h00000000;
			seg_release <= 1'b0;
			seg_include_buffered <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			trail_ff <= nxt_trail;
			seg_release <= nxt_release;
			seg_include_buffered <= ~imm_mode;
			if (ser_valid) begin
				prev_char_ff <= ser_data;
			end
			// Flush beats a new character: the buffer it counts is gone
			if (s2n_flush | nxt_release) begin
				pend_ff <= 16'h0000;
			end else if (ser_valid & (pend_ff != 16'hFFFF)) begin
				pend_ff <= pend_ff + 16'h0001;
			end
			// Each character restarts the wait; it also spaces successive segments
			if (ser_valid | nxt_release) begin
				timer_ff <= wait_cyc;
			end else if (timer_ff != 32'h00000000) begin
				timer_ff <= timer_ff - 32'h00000001;
			end
		end
	end

	// State indicator blinks in a session unless held off
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			blink_cnt_ff <= 32'h00000000;
			blink_ff <= 1'b0;
			state_led <= 1'b0;
		end else begin
			if (blink_cnt_ff == 32'h00000000) begin
				blink_cnt_ff <= BLINK_CYC;
				blink_ff <= ~blink_ff;
			end else begin
				blink_cnt_ff <= blink_cnt_ff - 32'h00000001;
			end
			if (!sess_active) begin
				state_led <= 1'b1;
			end else begin
				state_led <= disc_ff[`SNSP_DISC_LEDOFF] ? 1'b0 : blink_ff;
			end
		end
	end

endmodule // snsp_top

`default_nettype wire

// ---- core/snsp_consts.vh ----
`ifndef SNSP_CONSTS_VH
`define SNSP_CONSTS_VH

// Register byte addresses
`define SNSP_ADDR_DISC 8'h00
`define SNSP_ADDR_FLUSH 8'h04
`define SNSP_ADDR_PACK 8'h08
`define SNSP_ADDR_TRIG 8'h0C
`define SNSP_ADDR_OPT 8'h10
`define SNSP_ADDR_RIP 8'h14
`define SNSP_ADDR_RPORT 8'h18
`define SNSP_ADDR_STAT 8'h1C

// Reset values
`define SNSP_RST_BYTE 8'h00
`define SNSP_RST_OPT 3'h3
`define SNSP_RST_WORD 32'h00000000
`define SNSP_RST_PORT 16'h0000

// Disconnect policy fields
`define SNSP_DISC_MCTL 7
`define SNSP_DISC_COMCTL 6
`define SNSP_DISC_EOT 5
`define SNSP_DISC_PASSWD 4
`define SNSP_DISC_NOHARD 3
`define SNSP_DISC_LEDOFF 0

// Buffer flush policy fields
`define SNSP_FL_ALT 7
`define SNSP_FL_S2N_DISC 6
`define SNSP_FL_S2N_NET 5
`define SNSP_FL_S2N_DEV 4
`define SNSP_FL_N2S_DISC 2
`define SNSP_FL_N2S_NET 1
`define SNSP_FL_N2S_DEV 0

// Packing option fields
`define SNSP_PK_IV_HI 1
`define SNSP_PK_IV_LO 0
`define SNSP_PK_TR_HI 3
`define SNSP_PK_TR_LO 2
`define SNSP_PK_SEQ 4
`define SNSP_PK_IMM 5

// Option register fields
`define SNSP_OPT_ESC 0
`define SNSP_OPT_RING 1
`define SNSP_OPT_AINC 2

// Encodings
`define SNSP_IV_12MS 2'h0
`define SNSP_IV_52MS 2'h1
`define SNSP_IV_250MS 2'h2
`define SNSP_TR_NONE 2'h0
`define SNSP_TR_ONE 2'h1
`define SNSP_TR_TWO 2'h2
`define SNSP_EOT_CHAR 8'h04
`define SNSP_NO_CHAR 8'h00

// Timing in own units
`define SNSP_CLK_MHZ 100
`define SNSP_T0_MS 12
`define SNSP_T1_MS 52
`define SNSP_T2_MS 250
`define SNSP_T3_SEC 5
`define SNSP_BLINK_MS 250

`endif

// ---- core/snsp_top_dummy_none.v ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- verif/snsp_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module snsp_chk (
	input wire logic clock,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ser_valid,
	input wire logic [7:0] ser_data,
	input wire logic modem_ctrl_in,
	input wire logic sess_active,
	input wire logic sess_open_dev,
	input wire logic sess_open_net,
	input wire logic sess_closed,
	input wire logic seg_release,
	input wire logic sess_drop,
	input wire logic com_port_ctrl_en,
	input wire logic send_term_type,
	input wire logic state_led,
	input wire logic s2n_flush,
	input wire logic n2s_flush
);
	// One clock domain, so clock and reset are given once
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// Bus answers after exactly one wait state, as a one-cycle pulse
	apb_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready) else $error("pready timing");
	apb_pulse_a: assert property (pready |=> !pready) else $error("pready held");
	err_resp_a: assert property (pslverr |-> pready && psel && penable) else $error("stray pslverr");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h00000000) else $error("prdata not idle");
	// Session side effects and their causes lie one cycle apart
	term_type_a: assert property (sess_open_dev && com_port_ctrl_en |=> send_term_type) else $error("no term type");
	drop_cause_a: assert property (sess_drop |-> $past(ser_valid && ser_data == 8'h04)
		|| ($past(modem_ctrl_in, 2) && !$past(modem_ctrl_in))) else $error("drop without cause");
	flush_cause_a: assert property (s2n_flush || n2s_flush |-> $past(sess_open_dev || sess_open_net || sess_closed))
		else $error("flush without event");
	led_idle_a: assert property (!sess_active |=> state_led) else $error("led off while idle");
	seg_pulse_a: assert property (seg_release |=> !seg_release) else $error("release held");
endmodule // snsp_chk
bind snsp_top snsp_chk snsp_chk_i (.clock, .nrst, .psel, .penable, .prdata, .pready, .pslverr, .ser_valid,
	.ser_data, .modem_ctrl_in, .sess_active, .sess_open_dev, .sess_open_net, .sess_closed, .seg_release,
	.sess_drop, .com_port_ctrl_en, .send_term_type, .state_led, .s2n_flush, .n2s_flush);
`default_nettype wire

// ---- verif/snsp_ser_dev.sv ----
`timescale 1ns/1ps
`default_nettype none
module snsp_ser_dev (
	input wire logic clock,
	output logic ser_valid,
	output logic [7:0] ser_data,
	output logic modem_ctrl_in
);
	// Idle line, handshake high
	initial begin
		ser_valid = 1'b0;
		ser_data = 8'hFF;
		modem_ctrl_in = 1'b1;
	end
	// One character per call; data shows its inverse once the strobe drops, so stale data never matches
	task automatic send(input logic [7:0] c);
		@(posedge clock);
		ser_valid <= 1'b1;
		ser_data <= c;
		@(posedge clock);
		ser_valid <= 1'b0;
		ser_data <= ~c;
		#1;
	endtask
endmodule // snsp_ser_dev
`default_nettype wire

// ---- verif/snsp_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module snsp_tb_top;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] rd;
	logic re;
	logic sess_active = 1'b0;
	logic [2:0] ev_in = 3'h0;
	logic status_seg_req = 1'b0;
	int bad_count = 0;
	int tests_run = 0;
	int n;
	wire logic [31:0] prdata;
	wire logic [7:0] ser_data;
	wire logic pready, pslverr, ser_valid, modem_ctrl_in, seg_release, sess_drop, hard_close_en, state_led;
	wire logic com_port_ctrl_en, send_term_type, password_req, s2n_flush, n2s_flush;
	wire logic seg_include_buffered, escape_en, ring_ip_en;
	wire logic [31:0] remote_ip;
	wire logic [15:0] remote_port;
	wire logic [15:0] local_port;
	// Address, write data, read-back, error
	localparam logic [72:0] ROWS [8] = '{
		{8'h00, 32'h000000A5, 32'h000000A5, 1'b0},
		{8'h04, 32'hFFFFFF12, 32'h00000012, 1'b0},
		{8'h08, 32'h00000077, 32'h00000077, 1'b0},
		{8'h0C, 32'hABCD0D41, 32'h00000D41, 1'b0},
		{8'h10, 32'hFFFFFFF8, 32'h00000000, 1'b0},
		{8'h14, 32'hC0A80001, 32'hC0A80001, 1'b0},
		{8'h18, 32'h12340017, 32'h00000017, 1'b0},
		{8'h30, 32'hFFFFFFFF, 32'h00000000, 1'b1}
	};
	always #5 clock = ~clock;
	// Short counts keep the packing waits to tens of cycles
	snsp_top #(.PACK_T0_CYC(50), .PACK_T1_CYC(60), .PACK_T2_CYC(70), .PACK_T3_CYC(80), .BLINK_CYC(8)) snsp_top_i (
		.clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ser_valid,
		.ser_data, .modem_ctrl_in, .sess_active, .sess_open_dev(ev_in[2]), .sess_open_net(ev_in[1]),
		.sess_closed(ev_in[0]), .status_seg_req, .seg_release, .seg_include_buffered, .sess_drop,
		.hard_close_en, .com_port_ctrl_en, .send_term_type, .password_req, .state_led, .s2n_flush, .n2s_flush,
		.escape_en, .ring_ip_en, .remote_ip, .remote_port, .local_port);
	snsp_ser_dev snsp_ser_dev_i (.clock, .ser_valid, .ser_data, .modem_ctrl_in);
	task automatic chk(input string nm, input logic [32:0] got, input logic [32:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Request held until pready is seen at an edge; read data taken at that edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk("apb_wait", n < 20, 1'b1);
		if (n == 20) conclude();
		rd = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic ev(input logic [2:0] k, input logic [2:0] e);
		@(posedge clock);
		ev_in <= k;
		@(posedge clock);
		ev_in <= 3'h0;
		#1 chk("event", {s2n_flush, n2s_flush, send_term_type}, e);
	endtask
	initial begin
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		apb(1'b0, 8'h10, 32'h0);
		chk("opt_rst", rd, 3'h3);
		chk("opt_lvl", {escape_en, ring_ip_en, local_port}, {2'b11, 16'h2710});
		foreach (ROWS[i]) begin
			apb(1'b1, ROWS[i][72:65], ROWS[i][64:33]);
			apb(1'b0, ROWS[i][72:65], 32'h0);
			chk("rdback", {rd, re}, ROWS[i][32:0]);
		end
		chk("remote_ip", remote_ip, 32'hC0A80001);
		chk("remote_port", remote_port, 16'h0017);
		// Standard scheme: only the trigger releases at once
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h0C, 32'h0D);
		snsp_ser_dev_i.send(8'h41);
		chk("no_trig", seg_release, 1'b0);
		snsp_ser_dev_i.send(8'h0D);
		chk("trig", seg_release, 1'b1);
		// Status request releases a segment outside the packing rules
		@(posedge clock);
		status_seg_req <= 1'b1;
		@(posedge clock);
		status_seg_req <= 1'b0;
		#1 chk("status", seg_release, 1'b1);
		// Alternate scheme: each interval code times out at its own count
		apb(1'b1, 8'h04, 32'h80);
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, 8'h08, 32'(k));
			snsp_ser_dev_i.send(8'h41);
			n = 0;
			while (seg_release !== 1'b1 && n < 200) begin
				@(posedge clock);
				#1;
				n++;
			end
			chk("interval", 33'((n + 3) / 10), 33'(k + 5));
			if (n == 200) conclude();
		end
		chk("incl", seg_include_buffered, 1'b1);
		apb(1'b1, 8'h08, 32'h20);
		@(posedge clock);
		#1 chk("imm", seg_include_buffered, 1'b0);
		sess_active <= 1'b1;
		apb(1'b1, 8'h00, 32'h60);
		repeat (2) @(posedge clock);
		#1 chk("levels", {hard_close_en, password_req, com_port_ctrl_en}, 3'b101);
		snsp_ser_dev_i.send(8'h04);
		chk("eot", sess_drop, 1'b1);
		apb(1'b1, 8'h00, 32'h5F);
		repeat (2) @(posedge clock);
		#1 chk("levels2", {hard_close_en, password_req, com_port_ctrl_en, state_led}, 4'b0110);
		snsp_ser_dev_i.send(8'h04);
		chk("no_eot", sess_drop, 1'b0);
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, 8'h00, k ? 32'h0 : 32'h80);
			@(posedge clock);
			snsp_ser_dev_i.modem_ctrl_in <= 1'b0;
			@(posedge clock);
			#1 chk("modem", sess_drop, k == 0);
			snsp_ser_dev_i.modem_ctrl_in <= 1'b1;
		end
		apb(1'b1, 8'h00, 32'h40);
		apb(1'b1, 8'h04, 32'h52);
		ev(3'b100, 3'b101);
		ev(3'b010, 3'b010);
		ev(3'b001, 3'b100);
		// Auto-increment steps the local port on a new session
		apb(1'b1, 8'h10, 32'h4);
		ev(3'b100, 3'b101);
		chk("autoinc", local_port, 16'h2711);
		conclude();
	end
endmodule // snsp_tb_top
`default_nettype wire
